//--- shared/rtcca_pkg.sv
// Constants, register map and carrier types of the real-time clock block
package rtcca_pkg;

    // ============================================================
    // Timing
    localparam int XTAL_HZ = 32768;
    localparam int TICK_HZ = 1;
    localparam int PRESCALE_DEFAULT = XTAL_HZ / TICK_HZ;

    // ============================================================
    // Counter limits
    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [5:0] MIN_LAST = 6'h3b;
    localparam logic [4:0] HOUR_LAST = 5'h17;

    // ============================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CLOCK = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ALARM_TOD = 8'h0c;
    localparam logic [7:0] ADDR_ALARM_DAY = 8'h10;
    localparam logic [7:0] ADDR_SWATCH = 8'h14;
    localparam logic [7:0] ADDR_SWCTL = 8'h18;

    // ============================================================
    // Event / status bit positions
    localparam int EVT_SEC = 0;
    localparam int EVT_MIN = 1;
    localparam int EVT_HOUR = 2;
    localparam int EVT_DAY = 3;
    localparam int EVT_ALARM_TOD = 4;
    localparam int EVT_ALARM_DAY = 5;
    localparam int EVT_SWATCH = 6;
    localparam int NUM_EVT = 7;

    localparam int SWCTL_RUN = 0;

    // ============================================================
    // Reset values
    localparam logic [NUM_EVT-1:0] EVT_ZERO = 7'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [31:0] SW_DEC = 32'h00000001;

    // ============================================================
    // Carrier: packed time word, also the register layout
    typedef struct packed {
        logic [14:0] day;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } rtcca_time_t;

    localparam rtcca_time_t TIME_ZERO = '{day: 15'h0000, hour: 5'h00, min: 6'h00, sec: 6'h00};

    // Bus write captured at the address phase
    typedef struct packed {
        logic pend;
        logic [7:0] addr;
    } rtcca_wreq_t;

endpackage : rtcca_pkg

//--- hw/rtcca_prescaler.sv
// Crystal clock synchroniser and prescaler to the one-second tick
`timescale 1ns/1ps
module rtcca_prescaler
    import rtcca_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DEFAULT
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic xtalClk,
    output logic secTick
);
    import rtcca_pkg::*;

    localparam logic [15:0] CNT_LAST = 16'(PRESCALE - 1);
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    logic sync1_q, sync2_q, sync3_q;
    logic [15:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic xtalRise;

    // ============================================================
    // Crystal edge detection, after a two-stage synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= xtalClk;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign xtalRise = sync2_q & ~sync3_q;

    // ============================================================
    // Divide crystal edges down to one pulse per second
    always_comb
    begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (xtalRise)
        begin
            if (cnt_q == CNT_LAST)
            begin
                cnt_d = CNT_ZERO;
                tick_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + CNT_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_q <= CNT_ZERO;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign secTick = tick_q;

endmodule : rtcca_prescaler

//--- hw/rtcca_top.sv
// Real-time clock with calendar day count, two alarms and stopwatch
`timescale 1ns/1ps

// Overview of operation
// - Divide the crystal clock by a prescaler to a one-second tick.
// - Each tick advances seconds mod 60, carrying to minutes mod 60, hours mod 24.
// - Hour wrap advances a 15-bit day counter with 32768 values.
// - Enabled alarm raises interrupt when running time equals the alarm value.
// - First alarm compares hours, minutes and seconds only, firing daily.
// - Second alarm compares day plus hours, minutes and seconds.
// - Stopwatch loads a written value and decrements once per tick.
// - Enabled stopwatch interrupt fires on the first tick after the count has reached zero.
// - Separately enabled interrupts on second, minute, hour and day rollovers.
// - Timekeeping is clocked by ref_clk, with the crystal only sampled, so it stops if ref_clk stops.
module rtcca_top
    import rtcca_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DEFAULT
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic xtalClk,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq
);
    import rtcca_pkg::*;

    logic secTick;
    logic accept;
    logic tickDly_q;

    rtcca_time_t time_q, time_d;
    rtcca_time_t almTod_q, almTod_d;
    rtcca_time_t almDay_q, almDay_d;
    logic [NUM_EVT-1:0] mask_q, mask_d;
    logic [NUM_EVT-1:0] status_q, status_d;
    logic [NUM_EVT-1:0] evt;
    logic [31:0] swCount_q, swCount_d;
    logic swRun_q, swRun_d;
    rtcca_wreq_t wreq_q, wreq_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic secWrap, minWrap, hourWrap;
    logic swUnder;

    // Write to a given register in this data phase
    function automatic logic wrHit(input rtcca_wreq_t w, input logic [7:0] a);
        wrHit = w.pend && (w.addr == a);
    endfunction : wrHit

    // Zero-extend an event vector to a bus word
    function automatic logic [31:0] evtWord(input logic [NUM_EVT-1:0] v);
        evtWord = {{(32 - NUM_EVT){1'b0}}, v};
    endfunction : evtWord

    // ============================================================
    // Prescaler
    // Crystal domain only feeds the tick, so no gating input can stop time
    rtcca_prescaler #(
        .PRESCALE(PRESCALE)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .reset(reset),
        .xtalClk(xtalClk),
        .secTick(secTick)
    );

    // ============================================================
    // Bus slave
    // Only the low address byte decodes, so the map repeats every 256 bytes
    assign accept = hsel && htrans[1] && hready;

    always_comb
    begin
        wreq_d.pend = accept && hwrite;
        wreq_d.addr = haddr[7:0];
        rdata_d = rdata_q;
        if (accept && !hwrite)
        begin
            // Captured in one edge, so all time fields share a tick
            case (haddr[7:0])
                ADDR_CLOCK: rdata_d = time_q;
                ADDR_MASK: rdata_d = evtWord(mask_q);
                ADDR_STATUS: rdata_d = evtWord(status_q);
                ADDR_ALARM_TOD: rdata_d = almTod_q;
                ADDR_ALARM_DAY: rdata_d = almDay_q;
                ADDR_SWATCH: rdata_d = swCount_q;
                ADDR_SWCTL: rdata_d = {31'h00000000, swRun_q};
                default: rdata_d = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wreq_q <= '{pend: 1'b0, addr: 8'h00};
            rdata_q <= WORD_ZERO;
        end
        else
        begin
            wreq_q <= wreq_d;
            rdata_q <= rdata_d;
        end
    end

    // No wait states: every register answers in its data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // ============================================================
    // Time counters
    // Carries ripple within one cycle, so all fields move on the same edge
    assign secWrap = secTick && (time_q.sec == SEC_LAST);
    assign minWrap = secWrap && (time_q.min == MIN_LAST);
    assign hourWrap = minWrap && (time_q.hour == HOUR_LAST);

    always_comb
    begin
        time_d = time_q;
        if (secTick)
        begin
            time_d.sec = secWrap ? 6'h00 : time_q.sec + 6'h01;
            if (secWrap)
            begin
                time_d.min = minWrap ? 6'h00 : time_q.min + 6'h01;
            end
            if (minWrap)
            begin
                time_d.hour = hourWrap ? 5'h00 : time_q.hour + 5'h01;
            end
            if (hourWrap)
            begin
                // Wraps naturally after the last of its 32768 values
                time_d.day = time_q.day + 15'h0001;
            end
        end
        // Software load wins over a tick in the same cycle
        if (wrHit(wreq_q, ADDR_CLOCK))
        begin
            time_d = hwdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            time_q <= TIME_ZERO;
            tickDly_q <= 1'b0;
        end
        else
        begin
            time_q <= time_d;
            tickDly_q <= secTick;
        end
    end

    // ============================================================
    // Alarms and mask
    always_comb
    begin
        almTod_d = almTod_q;
        almDay_d = almDay_q;
        mask_d = mask_q;
        // Day field of the daily alarm is kept but never compared
        if (wrHit(wreq_q, ADDR_ALARM_TOD))
        begin
            almTod_d = hwdata;
        end
        if (wrHit(wreq_q, ADDR_ALARM_DAY))
        begin
            almDay_d = hwdata;
        end
        if (wrHit(wreq_q, ADDR_MASK))
        begin
            mask_d = hwdata[NUM_EVT-1:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            almTod_q <= TIME_ZERO;
            almDay_q <= TIME_ZERO;
            mask_q <= EVT_ZERO;
        end
        else
        begin
            almTod_q <= almTod_d;
            almDay_q <= almDay_d;
            mask_q <= mask_d;
        end
    end

    // ============================================================
    // Stopwatch
    assign swUnder = secTick && swRun_q && (swCount_q == WORD_ZERO);

    always_comb
    begin
        swCount_d = swCount_q;
        swRun_d = swRun_q;
        if (secTick && swRun_q)
        begin
            if (swUnder)
            begin
                // Stops at zero rather than wrapping to a huge count
                swRun_d = 1'b0;
            end
            else
            begin
                swCount_d = swCount_q - SW_DEC;
            end
        end
        // Reload wins over a same-cycle tick, so a new count is never lost
        if (wrHit(wreq_q, ADDR_SWATCH))
        begin
            swCount_d = hwdata;
            swRun_d = 1'b1;
        end
        if (wrHit(wreq_q, ADDR_SWCTL))
        begin
            swRun_d = hwdata[SWCTL_RUN];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            swCount_q <= WORD_ZERO;
            swRun_q <= 1'b0;
        end
        else
        begin
            swCount_q <= swCount_d;
            swRun_q <= swRun_d;
        end
    end

    // ============================================================
    // Events, sticky status and interrupt
    always_comb
    begin
        evt = EVT_ZERO;
        evt[EVT_SEC] = secTick;
        evt[EVT_MIN] = secWrap;
        evt[EVT_HOUR] = minWrap;
        evt[EVT_DAY] = hourWrap;
        // Compared one cycle after the tick, against the advanced time
        evt[EVT_ALARM_TOD] = tickDly_q && (time_q.hour == almTod_q.hour)
            && (time_q.min == almTod_q.min) && (time_q.sec == almTod_q.sec);
        evt[EVT_ALARM_DAY] = tickDly_q && (time_q == almDay_q);
        evt[EVT_SWATCH] = swUnder;
    end

    always_comb
    begin
        status_d = status_q;
        if (wrHit(wreq_q, ADDR_STATUS))
        begin
            status_d = status_q & ~hwdata[NUM_EVT-1:0];
        end
        // Set wins over a same-cycle clear
        status_d = status_d | evt;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            status_q <= EVT_ZERO;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    assign irq = irq_q;

endmodule : rtcca_top

//--- tb/rtcca_checker.sv
// Port-level assertions for the real-time clock top
`timescale 1ns/1ps
module rtcca_checker
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic xtalClk,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq
);
    logic rdTake;
    logic wrTake;
    logic xtalPrev_q;
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    assign rdTake = hsel && htrans[1] && hready && !hwrite;
    assign wrTake = hsel && htrans[1] && hready && hwrite;
    // ====
    // Cycles with no crystal edge and no write
    always_comb
    begin
        quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
        if (reset || wrTake || xtalClk != xtalPrev_q)
            quiet_d = 4'h0;
    end
    always_ff @(posedge ref_clk)
    begin
        xtalPrev_q <= xtalClk;
        quiet_q <= quiet_d;
    end
    // ====
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_resetIdle; $fell(reset) |-> !irq && hrdata == 32'h0; endproperty
    a_resetIdle: assert property (p_resetIdle) else $error("busy after reset");
    property p_busOkay; hreadyout && !hresp; endproperty
    a_busOkay: assert property (p_busOkay) else $error("bus not ready or error");
    property p_rdStands; !$stable(hrdata) |-> $past(rdTake); endproperty
    a_rdStands: assert property (p_rdStands) else $error("read data moved");
    property p_unmapped; rdTake && haddr[7:0] > 8'h18 |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_flagWidth;
        rdTake && (haddr[7:0] == 8'h04 || haddr[7:0] == 8'h08) |=> hrdata[31:7] == 25'h0;
    endproperty
    a_flagWidth: assert property (p_flagWidth) else $error("flag bits too wide");
    property p_clockRange;
        rdTake && haddr[7:0] == 8'h00 |=> hrdata[5:0] <= 6'h3b && hrdata[11:6] <= 6'h3b
            && hrdata[16:12] <= 5'h17;
    endproperty
    a_clockRange: assert property (p_clockRange) else $error("time out of range");
    property p_irqFall;
        $fell(irq) |-> $past(wrTake, 2) || $past(wrTake, 3) || $past(wrTake, 4);
    endproperty
    a_irqFall: assert property (p_irqFall) else $error("irq fell unprompted");
    // Ticks only come from crystal edges
    property p_irqQuiet; quiet_q >= 4'hc |-> $stable(irq); endproperty
    a_irqQuiet: assert property (p_irqQuiet) else $error("irq moved idle");
endmodule : rtcca_checker

bind rtcca_top rtcca_checker u_chk (.ref_clk(ref_clk), .reset(reset), .xtalClk(xtalClk),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

//--- tb/rtcca_tb_top.sv
// Self-checking bench of the real-time clock block
`timescale 1ns/1ps
module rtcca_tb_top;
    import rtcca_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic xtalClk = 1'b0;
    logic xtalRun = 1'b0;
    logic [1:0] xtalCnt = 2'h0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    logic [31:0] rd;
    logic [31:0] st;
    logic [31:0] tm;
    int err_count = 0;
    int checks_done = 0;
    // Short prescale keeps a second at 32 cycles
    rtcca_top #(.PRESCALE(4)) dut (.ref_clk(ref_clk), .reset(reset), .xtalClk(xtalClk),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .irq(irq));
    always #2 ref_clk = ~ref_clk;
    // Crystal stands still between ticks so reads are deterministic
    always @(posedge ref_clk)
    begin
        if (xtalRun)
        begin
            xtalCnt <= xtalCnt + 2'h1;
            if (xtalCnt == 2'h3)
                xtalClk <= ~xtalClk;
        end
    end
    // ====
    // Bus and check tasks
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic waitRdy;
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge ref_clk);
        end
        if (hreadyout !== 1'b1)
        begin
            err_count++;
            stop_test();
        end
    endtask : waitRdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask : xfer
    function automatic logic [31:0] tv(input logic [14:0] d, input logic [4:0] h,
        input logic [5:0] m, input logic [5:0] s);
        return {d, h, m, s};
    endfunction : tv
    // Clears status, runs the crystal up to one tick, then samples
    task automatic tick;
        int n;
        n = 0;
        xfer(1'b1, ADDR_STATUS, 32'h7f);
        xtalRun <= 1'b1;
        rd = 32'h0;
        while (rd === 32'h0 && n < 100)
        begin
            n++;
            xfer(1'b0, ADDR_STATUS, 32'h0);
        end
        xtalRun <= 1'b0;
        if (rd === 32'h0)
        begin
            err_count++;
            stop_test();
        end
        repeat (4) @(posedge ref_clk);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        st = rd;
        xfer(1'b0, ADDR_CLOCK, 32'h0);
        tm = rd;
    endtask : tick
    // ====
    // Main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 32; a += 4)
        begin
            xfer(1'b0, a[7:0], 32'h0);
            chk("reset value", rd, 32'h0);
        end
        xfer(1'b1, ADDR_MASK, 32'hffffffff);
        xfer(1'b0, ADDR_MASK, 32'h0);
        chk("mask", rd, 32'h7f);
        xfer(1'b1, 8'h1c, 32'hffffffff);
        xfer(1'b0, 8'h1c, 32'h0);
        chk("unmapped", rd, 32'h0);
        xfer(1'b1, ADDR_MASK, 32'h0);
        xfer(1'b1, ADDR_CLOCK, tv(15'h7fff, 5'h17, 6'h3b, 6'h3a));
        xfer(1'b1, ADDR_ALARM_TOD, tv(15'h0007, 5'h00, 6'h00, 6'h00));
        xfer(1'b1, ADDR_ALARM_DAY, tv(15'h0000, 5'h00, 6'h00, 6'h00));
        tick();
        chk("time", tm, tv(15'h7fff, 5'h17, 6'h3b, 6'h3b));
        chk("status", st, 32'h01);
        tick();
        chk("time", tm, 32'h0);
        chk("status", st, 32'h3f);
        xfer(1'b1, ADDR_STATUS, 32'h01);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h3e);
        xfer(1'b1, ADDR_CLOCK, tv(15'h0001, 5'h17, 6'h3b, 6'h3b));
        tick();
        chk("time", tm, tv(15'h0002, 5'h00, 6'h00, 6'h00));
        chk("status", st, 32'h1f);
        xfer(1'b1, ADDR_SWATCH, 32'h2);
        for (int k = 1; k <= 3; k++)
        begin
            tick();
            chk("status", st, (k == 3) ? 32'h41 : 32'h01);
            xfer(1'b0, ADDR_SWATCH, 32'h0);
            chk("countdown", rd, (k == 1) ? 32'h1 : 32'h0);
        end
        xfer(1'b0, ADDR_SWCTL, 32'h0);
        chk("run", rd, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        xfer(1'b1, ADDR_MASK, 32'h40);
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        xfer(1'b1, ADDR_STATUS, 32'h40);
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        xfer(1'b1, ADDR_MASK, 32'h01);
        tick();
        chk("irq", {31'h0, irq}, 32'h1);
        xfer(1'b0, ADDR_ALARM_TOD, 32'h0);
        chk("alarm", rd, tv(15'h0007, 5'h00, 6'h00, 6'h00));
        xfer(1'b1, ADDR_SWATCH, 32'h5);
        xfer(1'b1, ADDR_SWCTL, 32'h0);
        tick();
        chk("status", st, 32'h01);
        xfer(1'b0, ADDR_SWATCH, 32'h0);
        chk("held count", rd, 32'h5);
        xfer(1'b1, ADDR_SWCTL, 32'h1);
        tick();
        xfer(1'b0, ADDR_SWATCH, 32'h0);
        chk("resumed count", rd, 32'h4);
        xfer(1'b0, ADDR_SWCTL, 32'h0);
        chk("run", rd, 32'h1);
        stop_test();
    end
endmodule : rtcca_tb_top
